// ### hdl/oat_tick_gen.sv
// duration tick generator for the overtemperature assertion timer
`default_nettype none

module oat_tick_gen
  import oat_pkg::*;
#(
  parameter int TICK_CYCLES = OAT_TICK_CYCLES
) (
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset, high
  input wire logic restart, // zero the phase, start of an assertion
  input wire logic run, // count while high
  output logic tick // one-cycle pulse per tick period
);

  localparam int PW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [PW-1:0] LAST = PW'(TICK_CYCLES - 1);

  logic [PW-1:0] phase_reg;

  // ------------------------------------------------------------------
  // phase counter
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_reg <= '0;
    end else if (restart || !run) begin
      phase_reg <= '0;
    end else if (phase_reg == LAST) begin
      phase_reg <= '0;
    end else begin
      phase_reg <= phase_reg + PW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tick <= 1'b0;
    end else begin
      tick <= run && !restart && (phase_reg == LAST);
    end
  end

  AST_TICK_PERIOD: assert property (
    @(posedge clk) disable iff (rst)
    $rose(tick) |-> $past(phase_reg) == LAST
  ) else $error("tick not at end of period");

endmodule

`default_nettype wire

// ### hdl/oat_timer_top.sv
// overtemperature assertion timer with axi4-lite register slave
`default_nettype none

module oat_timer_top
  import oat_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int TICK_CYCLES = OAT_TICK_CYCLES
) (
  input wire logic SYS_CLK, // system clock, 125 MHz
  input wire logic RST, // synchronous reset, high
  input wire logic OVERTEMP_SIGNAL_N, // overtemperature input, active low
  input wire logic [ADDR_W-1:0] AWADDR, // write address
  input wire logic AWVALID, // write address valid
  output logic AWREADY, // write address ready
  input wire logic [31:0] WDATA, // write data
  input wire logic [3:0] WSTRB, // write byte strobes
  input wire logic WVALID, // write data valid
  output logic WREADY, // write data ready
  output logic [1:0] BRESP, // write response
  output logic BVALID, // write response valid
  input wire logic BREADY, // write response ready
  input wire logic [ADDR_W-1:0] ARADDR, // read address
  input wire logic ARVALID, // read address valid
  output logic ARREADY, // read address ready
  output logic [31:0] RDATA, // read data
  output logic [1:0] RRESP, // read response
  output logic RVALID, // read data valid
  input wire logic RREADY, // read data ready
  output logic IRQ // level interrupt, high
);

  // ------------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------------
  function automatic oat_sel_t decode(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-3:0] idx;
    idx = a[ADDR_W-1:2];
    if (idx == (ADDR_W-2)'(OAT_IDX_TSTAT)) return OAT_SEL_TSTAT;
    if (idx == (ADDR_W-2)'(OAT_IDX_TLIMIT)) return OAT_SEL_TLIMIT;
    if (idx == (ADDR_W-2)'(OAT_IDX_ISTAT)) return OAT_SEL_ISTAT;
    if (idx == (ADDR_W-2)'(OAT_IDX_IEN)) return OAT_SEL_IEN;
    if (idx == (ADDR_W-2)'(OAT_IDX_ICLR)) return OAT_SEL_ICLR;
    if (idx == (ADDR_W-2)'(OAT_IDX_CTRL)) return OAT_SEL_CTRL;
    return OAT_SEL_NONE;
  endfunction

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  logic aw_got_reg;
  logic w_got_reg;
  logic ar_got_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [ADDR_W-1:0] araddr_reg;
  logic [7:0] wdata_reg;
  logic wstrb0_reg;
  logic wr_do;
  logic rd_do;
  oat_sel_t wsel;
  oat_sel_t rsel;
  logic wr_lane;
  oat_ctrl_t ctrl_reg;
  logic [7:0] limit_reg;
  logic [7:0] istat_reg;
  logic [7:0] ien_reg;
  logic flag_reg;
  logic [7:0] cnt_reg;
  logic prev_reg;
  oat_state_t state_reg;
  oat_state_t state_next;
  logic asserted;
  logic start;
  logic tick;
  logic exceed;
  logic flag_clr;
  logic lim_clr;
  oat_tstat_t tstat;
  logic [7:0] rd_val;
  assign wr_do = aw_got_reg && w_got_reg && !BVALID;
  assign rd_do = ar_got_reg && !RVALID;
  assign wsel = decode(awaddr_reg);
  assign rsel = decode(araddr_reg);
  assign wr_lane = wr_do && wstrb0_reg;

  // ------------------------------------------------------------------
  // axi4-lite write channels
  // ------------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      AWREADY <= 1'b0;
      aw_got_reg <= 1'b0;
      awaddr_reg <= '0;
    end else if (AWREADY && AWVALID) begin
      AWREADY <= 1'b0;
      aw_got_reg <= 1'b1;
      awaddr_reg <= AWADDR;
    end else if (wr_do) begin
      aw_got_reg <= 1'b0;
    end else if (!aw_got_reg && !BVALID) begin
      AWREADY <= 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      WREADY <= 1'b0;
      w_got_reg <= 1'b0;
      wdata_reg <= 8'h00;
      wstrb0_reg <= 1'b0;
    end else if (WREADY && WVALID) begin
      WREADY <= 1'b0;
      w_got_reg <= 1'b1;
      wdata_reg <= WDATA[7:0];
      wstrb0_reg <= WSTRB[0];
    end else if (wr_do) begin
      w_got_reg <= 1'b0;
    end else if (!w_got_reg && !BVALID) begin
      WREADY <= 1'b1;
    end
  end

  // unmapped addresses answer slverr so software sees a bad pointer
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      BVALID <= 1'b0;
      BRESP <= OAT_RESP_OKAY;
    end else if (wr_do) begin
      BVALID <= 1'b1;
      BRESP <= (wsel == OAT_SEL_NONE) ? OAT_RESP_SLVERR : OAT_RESP_OKAY;
    end else if (BVALID && BREADY) begin
      BVALID <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // axi4-lite read channels
  // ------------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ARREADY <= 1'b0;
      ar_got_reg <= 1'b0;
      araddr_reg <= '0;
    end else if (ARREADY && ARVALID) begin
      ARREADY <= 1'b0;
      ar_got_reg <= 1'b1;
      araddr_reg <= ARADDR;
    end else if (rd_do) begin
      ar_got_reg <= 1'b0;
    end else if (!ar_got_reg && !RVALID) begin
      ARREADY <= 1'b1;
    end
  end

  always_comb begin
    rd_val = 8'h00;
    case (rsel)
      OAT_SEL_TSTAT: rd_val = tstat;
      OAT_SEL_TLIMIT: rd_val = limit_reg;
      OAT_SEL_ISTAT: rd_val = istat_reg;
      OAT_SEL_IEN: rd_val = ien_reg;
      OAT_SEL_CTRL: rd_val = ctrl_reg;
      default: rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      RVALID <= 1'b0;
      RDATA <= 32'h0000_0000;
      RRESP <= OAT_RESP_OKAY;
    end else if (rd_do) begin
      RVALID <= 1'b1;
      RDATA <= {24'h00_0000, rd_val};
      RRESP <= (rsel == OAT_SEL_NONE) ? OAT_RESP_SLVERR : OAT_RESP_OKAY;
    end else if (RVALID && RREADY) begin
      RVALID <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // software-written registers
  // ------------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      limit_reg <= OAT_TLIMIT_RST;
    end else if (wr_lane && wsel == OAT_SEL_TLIMIT) begin
      limit_reg <= wdata_reg;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ctrl_reg <= OAT_CTRL_RST;
      ien_reg <= OAT_IEN_RST;
    end else if (wr_lane && wsel == OAT_SEL_CTRL) begin
      ctrl_reg <= {7'h00, wdata_reg[0]};
    end else if (wr_lane && wsel == OAT_SEL_IEN) begin
      ien_reg <= wdata_reg;
    end
  end

  // ------------------------------------------------------------------
  // assertion detection and duration state
  // ------------------------------------------------------------------
  assign asserted = ctrl_reg.timer_en && !OVERTEMP_SIGNAL_N;
  assign start = asserted && !prev_reg;
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= asserted;
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      OAT_ST_IDLE: if (start) state_next = OAT_ST_RUN;
      OAT_ST_RUN: begin
        if (!asserted) begin
          state_next = OAT_ST_IDLE;
        end else if (tick && cnt_reg == OAT_CNT_MAX - 8'h01) begin
          state_next = OAT_ST_SAT;
        end
      end
      OAT_ST_SAT: if (!asserted) state_next = OAT_ST_IDLE;
      default: state_next = OAT_ST_IDLE;
    endcase
  end
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      state_reg <= OAT_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end
  oat_tick_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk(SYS_CLK),
    .rst(RST),
    .restart(start),
    .run(asserted),
    .tick(tick)
  );
  // count holds after release so software can still read the duration
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      cnt_reg <= OAT_TSTAT_RST;
    end else if (start) begin
      cnt_reg <= 8'h00;
    end else if (state_reg == OAT_ST_RUN && asserted && tick) begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

  // ------------------------------------------------------------------
  // timer status view and clear-on-read flag
  // ------------------------------------------------------------------
  always_comb begin
    if (cnt_reg >= OAT_REPORT_TICKS) begin
      tstat = cnt_reg;
    end else begin
      tstat = {7'h00, flag_reg};
    end
  end

  assign flag_clr = rd_do && rsel == OAT_SEL_TSTAT;
  // a new assertion in the cycle of the read keeps the flag set
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      flag_reg <= 1'b0;
    end else if (start) begin
      flag_reg <= 1'b1;
    end else if (flag_clr) begin
      flag_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // limit comparison and interrupt
  // ------------------------------------------------------------------
  // run state still holds at the release edge, so the last tick can flag
  assign exceed = (start && limit_reg == 8'h00)
    || (state_reg != OAT_ST_IDLE && cnt_reg > limit_reg);
  assign lim_clr = wr_lane && wsel == OAT_SEL_ICLR
    && wdata_reg[OAT_LIMIT_BIT];
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      istat_reg <= OAT_ISTAT_RST;
    end else if (exceed) begin
      istat_reg[OAT_LIMIT_BIT] <= 1'b1;
    end else if (lim_clr) begin
      istat_reg[OAT_LIMIT_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(istat_reg & ien_reg);
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  AST_UPPER_ZERO: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    (rd_do && rsel == OAT_SEL_TSTAT && cnt_reg < OAT_REPORT_TICKS)
      |=> RDATA[7:1] == 7'h00
  ) else $error("upper count bits not zero before report time");
  AST_FLAG_SET: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    $fell(OVERTEMP_SIGNAL_N) && ctrl_reg.timer_en && !prev_reg
      |=> flag_reg ##1 RVALID || flag_reg || flag_clr
  ) else $error("assertion flag not set on input assertion");
  AST_FLAG_CLR: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    flag_clr && !start |=> !flag_reg
  ) else $error("status read did not clear the assertion flag");
  AST_COUNT_REPORT: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    rd_do && rsel == OAT_SEL_TSTAT && cnt_reg >= OAT_REPORT_TICKS
      |=> RDATA[7:0] == $past(cnt_reg)
  ) else $error("count not reported once past report time");
  AST_LIMIT_WR: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    wr_lane && wsel == OAT_SEL_TLIMIT |=> limit_reg == $past(wdata_reg)
  ) else $error("limit register did not take written value");
  AST_LIMIT_HIT: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    state_reg != OAT_ST_IDLE && cnt_reg > limit_reg
      |=> istat_reg[OAT_LIMIT_BIT]
  ) else $error("limit exceeded but status bit not set");
  AST_ZERO_LIMIT: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    start && limit_reg == 8'h00 |=> istat_reg[OAT_LIMIT_BIT]
  ) else $error("zero limit did not flag at assertion");
  AST_ENABLE_GATES: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    !ctrl_reg.timer_en |=> state_reg == OAT_ST_IDLE
  ) else $error("timer running while disabled");
  AST_COUNT_STEP: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    state_reg == OAT_ST_RUN && asserted && tick && !start
      |=> cnt_reg == $past(cnt_reg) + 8'h01
  ) else $error("count did not advance on tick");
  AST_COUNT_SAT: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    cnt_reg == OAT_CNT_MAX && !start |=> cnt_reg == OAT_CNT_MAX
  ) else $error("count wrapped past saturation");

endmodule

`default_nettype wire

// ### inc/oat_pkg.sv
// shared constants and types for the overtemperature assertion timer
`default_nettype none

package oat_pkg;

  // ------------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ------------------------------------------------------------------
  localparam logic [7:0] OAT_IDX_TSTAT = 8'h79;
  localparam logic [7:0] OAT_IDX_TLIMIT = 8'h7A;
  localparam logic [7:0] OAT_IDX_ISTAT = 8'h42;
  localparam logic [7:0] OAT_IDX_IEN = 8'h43;
  localparam logic [7:0] OAT_IDX_ICLR = 8'h44;
  localparam logic [7:0] OAT_IDX_CTRL = 8'h10;

  // ------------------------------------------------------------------
  // reset values and field positions
  // ------------------------------------------------------------------
  localparam logic [7:0] OAT_TSTAT_RST = 8'h00;
  localparam logic [7:0] OAT_TLIMIT_RST = 8'h00;
  localparam logic [7:0] OAT_ISTAT_RST = 8'h00;
  localparam logic [7:0] OAT_IEN_RST = 8'h00;
  localparam logic [7:0] OAT_CTRL_RST = 8'h01;
  localparam int OAT_LIMIT_BIT = 5;
  localparam logic [7:0] OAT_CNT_MAX = 8'hFF;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam real OAT_TICK_MS = 22.76;
  localparam real OAT_REPORT_MS = 45.52;
  localparam real OAT_CLK_NS = 8.0;
  localparam int OAT_TICK_CYCLES = int'(OAT_TICK_MS * 1.0e6 / OAT_CLK_NS);
  localparam logic [7:0] OAT_REPORT_TICKS =
    8'(int'(OAT_REPORT_MS / OAT_TICK_MS));

  // ------------------------------------------------------------------
  // axi responses
  // ------------------------------------------------------------------
  localparam logic [1:0] OAT_RESP_OKAY = 2'h0;
  localparam logic [1:0] OAT_RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    OAT_ST_IDLE = 2'b00,
    OAT_ST_RUN = 2'b01,
    OAT_ST_SAT = 2'b11
  } oat_state_t;

  typedef enum logic [2:0] {
    OAT_SEL_NONE,
    OAT_SEL_TSTAT,
    OAT_SEL_TLIMIT,
    OAT_SEL_ISTAT,
    OAT_SEL_IEN,
    OAT_SEL_ICLR,
    OAT_SEL_CTRL
  } oat_sel_t;

  typedef struct packed {
    logic [6:0] rsvd;
    logic timer_en;
  } oat_ctrl_t;

  typedef struct packed {
    logic [6:0] upper;
    logic lsb;
  } oat_tstat_t;

endpackage

`default_nettype wire

// ### tb/oat_overtemp_signal_src.sv
// model of the system logic that drives the overtemperature input
`default_nettype none

module oat_overtemp_signal_src (
  input wire logic clk, // system clock
  input wire logic go, // start one assertion
  input wire logic [15:0] len, // cycles to hold the line low
  output logic overtemp_signal_n // overtemperature line, pulled up when idle
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] left_reg = 16'h0000;

  always_ff @(posedge clk) begin
    if (go) begin
      left_reg <= len;
    end else if (left_reg != 16'h0000) begin
      left_reg <= left_reg - 16'h0001;
    end
  end

  // released line floats back to the pull-up level
  assign overtemp_signal_n = (left_reg == 16'h0000);
endmodule

`default_nettype wire

// ### tb/tb_overtemp_assertion_timer.sv
// self-checking testbench for the overtemperature assertion timer
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  err_total++; $display("Error %s expected %h seen %h", nm, e, g); end end

module tb_overtemp_assertion_timer import oat_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------------
  // signals and rows
  // ------------------------------------------------------------------
  typedef struct {
    logic [7:0] lim;
    int hold;
    logic [7:0] st;
    logic f;
  } oat_row_t;
  // short tick keeps the saturation row near 2400 cycles
  localparam int TCK = 8;
  oat_row_t rows [9] = '{'{8'h00, 4, 8'h01, 1'b1}, '{8'h02, 28, 8'h03, 1'b1},
    '{8'h05, 12, 8'h01, 1'b0}, '{8'h03, 28, 8'h03, 1'b0},
    '{8'h01, 17, 8'h01, 1'b0}, '{8'h01, 18, 8'h02, 1'b1},
    '{8'h05, 44, 8'h05, 1'b0}, '{8'hFE, 2400, 8'hFF, 1'b1},
    '{8'hFF, 2400, 8'hFF, 1'b0}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic go = 1'b0;
  logic [15:0] len = 16'h0000;
  logic overtemp_signal_n;
  logic [11:0] awaddr = 12'h000;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic [3:0] strb = 4'hF;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [11:0] araddr = 12'h000;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic irq;
  int err_total = 0;
  int samples_checked = 0;

  always #4 clk = ~clk;

  oat_timer_top #(.ADDR_W(12), .TICK_CYCLES(TCK)) u_dut (
    .SYS_CLK(clk), .RST(rst), .OVERTEMP_SIGNAL_N(overtemp_signal_n),
    .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .IRQ(irq));

  oat_overtemp_signal_src u_src (.clk(clk), .go(go), .len(len), .overtemp_signal_n(overtemp_signal_n));

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic tmo();
    err_total++;
    $display("Error handshake expected answer seen timeout");
    summarize();
  endtask

  // 2'h3 never comes back from this slave, so it marks a pending answer
  task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    r = 2'h3;
    @(posedge clk);
    awaddr <= 12'({idx, 2'b00});
    awvalid <= 1'b1;
    wdata <= {24'h0, d};
    wstrb <= strb;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        bready <= 1'b0;
      end
      if (n > 40) tmo();
    end while (r === 2'h3);
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    r = 2'h3;
    @(posedge clk);
    araddr <= 12'({idx, 2'b00});
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        r = rresp;
        d = rdata;
        rready <= 1'b0;
      end
      if (n > 40) tmo();
    end while (r === 2'h3);
  endtask

  task automatic chkr(input logic [7:0] idx, input logic [7:0] e,
                      input string nm);
    logic [31:0] d;
    logic [1:0] r;
    rd(idx, d, r);
    `CHK(nm, {24'h0, e}, d)
    `CHK("read response", OAT_RESP_OKAY, r)
  endtask

  task automatic wok(input logic [7:0] idx, input logic [7:0] d);
    logic [1:0] r;
    wr(idx, d, r);
    `CHK("write response", OAT_RESP_OKAY, r)
  endtask

  task automatic pulse(input int h);
    @(posedge clk);
    go <= 1'b1;
    len <= 16'(h);
    @(posedge clk);
    go <= 1'b0;
    repeat (h + 6) @(posedge clk);
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chkr(OAT_IDX_TSTAT, 8'h00, "status reset");
    chkr(OAT_IDX_TLIMIT, 8'h00, "limit reset");
    chkr(OAT_IDX_ISTAT, 8'h00, "int status reset");
    chkr(OAT_IDX_IEN, 8'h00, "int enable reset");
    chkr(OAT_IDX_CTRL, 8'h01, "control reset");
    $display("test reset values done");
    wok(OAT_IDX_IEN, 8'h20);
    foreach (rows[i]) begin
      wok(OAT_IDX_TLIMIT, rows[i].lim);
      wok(OAT_IDX_ICLR, 8'h20);
      rd(OAT_IDX_TSTAT, d, r);
      pulse(rows[i].hold);
      chkr(OAT_IDX_TSTAT, rows[i].st, "status");
      chkr(OAT_IDX_ISTAT, {2'b0, rows[i].f, 5'b0}, "int status");
      `CHK("irq", rows[i].f, irq)
      chkr(OAT_IDX_TSTAT, (rows[i].st >= 8'h02) ? rows[i].st : 8'h00,
           "status reread");
      $display("test row %0d done", i);
    end
    // masked event stays in status, interrupt follows the enable
    wok(OAT_IDX_IEN, 8'h00);
    wok(OAT_IDX_TLIMIT, 8'h00);
    wok(OAT_IDX_ICLR, 8'h20);
    pulse(4);
    chkr(OAT_IDX_ISTAT, 8'h20, "masked int status");
    `CHK("masked irq", 1'b0, irq)
    wok(OAT_IDX_IEN, 8'h20);
    chkr(OAT_IDX_ISTAT, 8'h20, "int status kept");
    `CHK("enabled irq", 1'b1, irq)
    wok(OAT_IDX_ICLR, 8'h20);
    chkr(OAT_IDX_ISTAT, 8'h00, "int status cleared");
    `CHK("cleared irq", 1'b0, irq)
    $display("test interrupt mask done");
    // timer switched off ignores the input
    wok(OAT_IDX_CTRL, 8'h00);
    rd(OAT_IDX_TSTAT, d, r);
    pulse(28);
    chkr(OAT_IDX_TSTAT, 8'h00, "status disabled");
    chkr(OAT_IDX_ISTAT, 8'h00, "int status disabled");
    wok(OAT_IDX_CTRL, 8'h01);
    $display("test timer disable done");
    wok(OAT_IDX_TLIMIT, 8'hA5);
    chkr(OAT_IDX_TLIMIT, 8'hA5, "limit readback");
    strb = 4'h0;
    wok(OAT_IDX_TLIMIT, 8'h3C);
    strb = 4'hF;
    chkr(OAT_IDX_TLIMIT, 8'hA5, "limit no strobe");
    rd(8'h55, d, r);
    `CHK("unmapped data", 32'h0, d)
    `CHK("unmapped read response", OAT_RESP_SLVERR, r)
    wr(8'h55, 8'h11, r);
    `CHK("unmapped write response", OAT_RESP_SLVERR, r)
    $display("test register access done");
    summarize();
  end

  initial begin
    repeat (100000) @(posedge clk);
    tmo();
  end
endmodule

`default_nettype wire
